// ==== design/srpc_pkg.sv ====
// shared constants and types of the synchronous dual-port ram
package srpc_pkg;
	localparam int ADDR_W    = 17;
	localparam int DATA_W    = 8;
	localparam int DEPTH     = 131072;
	localparam int PORTS     = 2;
	localparam int CLK_NS    = 10;
	// write port clock high to opposite port read data, longest
	localparam int CWDD_NS   = 35;
	localparam int CWDD_CYC  = CWDD_NS / CLK_NS;
	localparam int FT_LAT    = 1;
	localparam int PIPE_LAT  = 2;
	localparam logic [ADDR_W-1:0] COUNT_RST = 17'h00000;
	localparam logic [DATA_W-1:0] DATA_RST  = 8'h00;
	// host operations
	typedef enum logic [2:0] {
		OP_READ,
		OP_WRITE,
		OP_NEXT_READ,
		OP_NEXT_WRITE,
		OP_CLEAR_READ,
		OP_HOLD_READ
	} srpc_op_t;
endpackage

// ==== design/srpc_port_if.sv ====
// one port of the dual-port ram between controller and ram
`timescale 1ns/10ps
`default_nettype none
interface srpc_port_if;
	import srpc_pkg::*;
	logic              select_active_low;
	logic              select_active_high;
	logic              read_write;
	logic              address_strobe_n;
	logic              counter_advance_n;
	logic              counter_clear_n;
	logic              output_enable_n;
	logic              output_latency_select;
	logic [ADDR_W-1:0] address;
	logic [DATA_W-1:0] host_data;
	logic              host_data_oe_n;
	logic [DATA_W-1:0] ram_data;
	logic              ram_data_oe_n;
	modport device (
		input  select_active_low,
		input  select_active_high,
		input  read_write,
		input  address_strobe_n,
		input  counter_advance_n,
		input  counter_clear_n,
		input  output_enable_n,
		input  output_latency_select,
		input  address,
		input  host_data,
		output ram_data,
		output ram_data_oe_n
	);
	modport host (
		output select_active_low,
		output select_active_high,
		output read_write,
		output address_strobe_n,
		output counter_advance_n,
		output counter_clear_n,
		output output_enable_n,
		output output_latency_select,
		output address,
		output host_data,
		output host_data_oe_n,
		input  ram_data,
		input  ram_data_oe_n
	);
endinterface
`default_nettype wire

// ==== design/srpc_burst_counter.sv ====
// burst address counter of one ram port
`timescale 1ns/10ps
`default_nettype none
module srpc_burst_counter
	import srpc_pkg::*;
(
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              resetn_i,
	// control
	input  wire logic              load_n_i,
	input  wire logic              advance_n_i,
	input  wire logic              clear_n_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	// internal address
	output logic      [ADDR_W-1:0] addr_o,
	output logic      [ADDR_W-1:0] addr_next_o
);
	logic [ADDR_W-1:0] count_reg;
	logic [ADDR_W-1:0] count_next;

	always_comb
	begin
		if (!clear_n_i)
			count_next = COUNT_RST; // [RQ21] [RQ8]
		else if (!load_n_i)
			count_next = addr_i; // [RQ3] [RQ4]
		else if (!advance_n_i)
			count_next = count_reg + 17'h00001; // [RQ5]
		else
			count_next = count_reg; // [RQ6] [RQ7]
	end

	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
			count_reg <= COUNT_RST;
		else
			count_reg <= count_next;
	end

	assign addr_o      = count_reg;
	assign addr_next_o = count_next;
endmodule
`default_nettype wire

// ==== design/srpc_ram.sv ====
// dual-port synchronous ram, both ports on one clock
//
// How it works
// RQ1 - all port inputs captured on rising edge; output enable and latency select are used unregistered
// RQ2 - write done at capture edge, self-timed
// RQ3 - strobe low loads external address each edge
// RQ4 - access address: external or counter by strobe
// RQ5 - strobe high, advance low: address plus one
// RQ6 - strobe and advance high hold address, data
// RQ7 - advance high stalls the burst counter
// RQ8 - counter clear costs no dead cycle
// RQ9 - output enable gates drivers asynchronously
// RQ10 - deselected cycle powers down port array access
// RQ11 - pipelined output needs two selected cycles
// RQ12 - drive state set by previous cycle controls
// RQ13 - controller rewrites data after write then nop
// RQ14 - close cross-port read waits write delay
// RQ15 - far cross-port read: separation plus access
// RQ16 - both ports identical, either may write
// RQ17 - banks share address, chip enables pick one
// RQ18 - parallel controls give wider words
// RQ19 - latency select: high pipelined, low flow-through
// RQ20 - cross-port read data within write delay
// RQ21 - counter clear sets burst counter to zero
// RQ22 - pipelined mode adds one output register
// RQ23 - read-write high reads, low writes byte
`timescale 1ns/10ps
`default_nettype none
module srpc_ram
	import srpc_pkg::*;
(
	// clock and reset
	input  wire logic clock_i,
	input  wire logic resetn_i,
	// ram ports
	srpc_port_if.device port_a,
	srpc_port_if.device port_b
);
	// port signals gathered into arrays so both ports share one body
	wire logic              sel_lo   [PORTS];
	wire logic              sel_hi   [PORTS];
	wire logic              rd_wr    [PORTS];
	wire logic              strobe_n [PORTS];
	wire logic              adv_n    [PORTS];
	wire logic              clr_n    [PORTS];
	wire logic              oe_n     [PORTS];
	wire logic              lat_sel  [PORTS];
	wire logic [ADDR_W-1:0] ext_addr [PORTS];
	wire logic [DATA_W-1:0] din      [PORTS];
	wire logic [ADDR_W-1:0] acc_addr [PORTS];
	wire logic [ADDR_W-1:0] nxt_addr [PORTS];
	wire logic              sel_now  [PORTS];
	wire logic              wr_now   [PORTS];
	wire logic [DATA_W-1:0] dout     [PORTS];
	wire logic              dout_oen [PORTS];

	logic [DATA_W-1:0] mem [DEPTH];

	assign sel_lo[0]   = port_a.select_active_low;
	assign sel_hi[0]   = port_a.select_active_high;
	assign rd_wr[0]    = port_a.read_write;
	assign strobe_n[0] = port_a.address_strobe_n;
	assign adv_n[0]    = port_a.counter_advance_n;
	assign clr_n[0]    = port_a.counter_clear_n;
	assign oe_n[0]     = port_a.output_enable_n;
	assign lat_sel[0]  = port_a.output_latency_select;
	assign ext_addr[0] = port_a.address;
	assign din[0]      = port_a.host_data;

	assign sel_lo[1]   = port_b.select_active_low;
	assign sel_hi[1]   = port_b.select_active_high;
	assign rd_wr[1]    = port_b.read_write;
	assign strobe_n[1] = port_b.address_strobe_n;
	assign adv_n[1]    = port_b.counter_advance_n;
	assign clr_n[1]    = port_b.counter_clear_n;
	assign oe_n[1]     = port_b.output_enable_n;
	assign lat_sel[1]  = port_b.output_latency_select;
	assign ext_addr[1] = port_b.address;
	assign din[1]      = port_b.host_data;

	assign port_a.ram_data      = dout[0];
	assign port_a.ram_data_oe_n = dout_oen[0];
	assign port_b.ram_data      = dout[1];
	assign port_b.ram_data_oe_n = dout_oen[1];

	// identical logic for each port [RQ16]
	genvar p;
	generate
		for (p = 0; p < PORTS; p++)
		begin : g_port
			logic              sel_reg;
			logic              rd_reg;
			logic              act_reg;
			logic              drv_pipe_reg;
			logic [DATA_W-1:0] ft_reg;
			logic [DATA_W-1:0] pipe_reg;
			wire logic         drv_ft;
			wire logic         drv;

			srpc_burst_counter u_counter (
				.clock_i     (clock_i),
				.resetn_i    (resetn_i),
				.load_n_i    (strobe_n[p]),
				.advance_n_i (adv_n[p]),
				.clear_n_i   (clr_n[p]),
				.addr_i      (ext_addr[p]),
				.addr_o      (acc_addr[p]),
				.addr_next_o (nxt_addr[p])
			);

			// selected only with low enable low and high enable high
			assign sel_now[p] = !sel_lo[p] && sel_hi[p];
			assign wr_now[p]  = sel_now[p] && !rd_wr[p]; // [RQ23]

			always_ff @(posedge clock_i)
			begin
				if (!resetn_i)
				begin
					sel_reg      <= 1'b0;
					rd_reg       <= 1'b1;
					act_reg      <= 1'b0;
					drv_pipe_reg <= 1'b0;
					ft_reg       <= DATA_RST;
					pipe_reg     <= DATA_RST;
				end
				else
				begin
					sel_reg <= sel_now[p]; // [RQ1]
					rd_reg  <= rd_wr[p]; // [RQ1] [RQ23]
					act_reg <= sel_reg;
					// two selected captures before pipelined drive
					drv_pipe_reg <= sel_reg && rd_reg && act_reg; // [RQ11]
					// array is not read while deselected [RQ10]
					if (sel_now[p] && rd_wr[p])
						ft_reg <= mem[nxt_addr[p]]; // [RQ14] [RQ15] [RQ20]
					pipe_reg <= ft_reg; // [RQ22]
				end
			end

			// drive state from controls captured at the last edge
			assign drv_ft = sel_reg && rd_reg; // [RQ12]
			assign drv    = lat_sel[p] ? drv_pipe_reg : drv_ft; // [RQ19]
			assign dout[p]     = lat_sel[p] ? pipe_reg : ft_reg; // [RQ19]
			assign dout_oen[p] = oe_n[p] || !drv; // [RQ9]
		end
	endgenerate

	// write at the capture edge; port b wins a same-address collision
	always_ff @(posedge clock_i)
	begin
		if (wr_now[0])
			mem[nxt_addr[0]] <= din[0]; // [RQ2] [RQ23]
		if (wr_now[1])
			mem[nxt_addr[1]] <= din[1]; // [RQ2] [RQ16]
	end
endmodule
`default_nettype wire

// ==== design/srpc_host.sv ====
// controller end of one ram port
`timescale 1ns/10ps
`default_nettype none
module srpc_host
	import srpc_pkg::*;
(
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              resetn_i,
	// ram port
	srpc_port_if.host              ram,
	// user commands
	input  wire logic              cmd_valid_i,
	input  wire srpc_op_t          cmd_op_i,
	input  wire logic [ADDR_W-1:0] cmd_addr_i,
	input  wire logic [DATA_W-1:0] cmd_wdata_i,
	input  wire logic              pipelined_i,
	input  wire logic              bank_enable_i,
	output logic                   cmd_ready_o,
	// read answers
	output logic      [DATA_W-1:0] rdata_o,
	output logic                   rdata_valid_o
);
	logic              sel_reg, bank_reg, rw_reg, ads_reg, adv_reg;
	logic              clr_reg, pipe_reg, wr_reg, wrote_reg, rewrite_reg;
	logic [ADDR_W-1:0] addr_reg, mirror_reg, last_addr_reg;
	logic [DATA_W-1:0] wdata_reg, last_data_reg, rdata_reg;
	logic [2:0]        rd_sr_reg;
	logic              valid_reg;
	logic              sel_next, rw_next, ads_next, adv_next, clr_next;
	logic [ADDR_W-1:0] addr_next, mirror_next;
	logic [DATA_W-1:0] wdata_next;
	wire logic         wake_need;
	wire logic         take;
	wire logic         issue_rd;
	wire logic         valid_next;

	// a deselected pipelined port needs one selected cycle first [RQ11]
	assign wake_need   = pipelined_i && !sel_reg && cmd_valid_i;
	assign cmd_ready_o = !rewrite_reg && !wake_need;
	assign take        = cmd_valid_i && cmd_ready_o;
	// only taken reads answer; wake and replay cycles give no valid
	assign issue_rd    = take && rw_next && bank_enable_i;
	assign valid_next  = pipe_reg ? rd_sr_reg[2] : rd_sr_reg[1];

	always_comb
	begin
		sel_next   = take || rewrite_reg || wake_need;
		rw_next    = 1'b1;
		ads_next   = 1'b1;
		adv_next   = 1'b1;
		clr_next   = 1'b1;
		addr_next  = addr_reg;
		wdata_next = wdata_reg;
		if (rewrite_reg)
		begin
			// replay the last write after a nop [RQ13]
			ads_next   = 1'b0;
			rw_next    = 1'b0;
			addr_next  = last_addr_reg;
			wdata_next = last_data_reg;
		end
		else if (take)
		begin
			addr_next  = cmd_addr_i;
			wdata_next = cmd_wdata_i;
			case (cmd_op_i)
				OP_READ:       ads_next = 1'b0;
				OP_WRITE:
				begin
					ads_next = 1'b0;
					rw_next  = 1'b0;
				end
				OP_NEXT_READ:  adv_next = 1'b0;
				OP_NEXT_WRITE:
				begin
					adv_next = 1'b0;
					rw_next  = 1'b0;
				end
				OP_CLEAR_READ: clr_next = 1'b0;
				default:       rw_next  = 1'b1;
			endcase
		end
		// local copy of the ram's burst counter
		if (!clr_next)
			mirror_next = COUNT_RST;
		else if (!ads_next)
			mirror_next = addr_next;
		else if (!adv_next)
			mirror_next = mirror_reg + 17'h00001;
		else
			mirror_next = mirror_reg;
	end

	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
		begin
			sel_reg       <= 1'b0;
			bank_reg      <= 1'b0;
			rw_reg        <= 1'b1;
			ads_reg       <= 1'b1;
			adv_reg       <= 1'b1;
			clr_reg       <= 1'b1;
			pipe_reg      <= 1'b0;
			wr_reg        <= 1'b0;
			wrote_reg     <= 1'b0;
			rewrite_reg   <= 1'b0;
			addr_reg      <= COUNT_RST;
			mirror_reg    <= COUNT_RST;
			last_addr_reg <= COUNT_RST;
			wdata_reg     <= DATA_RST;
			last_data_reg <= DATA_RST;
			rdata_reg     <= DATA_RST;
			rd_sr_reg     <= 3'h0;
			valid_reg     <= 1'b0;
		end
		else
		begin
			sel_reg    <= sel_next;
			bank_reg   <= sel_next && bank_enable_i; // [RQ17]
			rw_reg     <= rw_next;
			ads_reg    <= ads_next;
			adv_reg    <= adv_next;
			clr_reg    <= clr_next;
			pipe_reg   <= pipelined_i;
			wr_reg     <= sel_next && !rw_next;
			addr_reg   <= addr_next;
			wdata_reg  <= wdata_next;
			mirror_reg <= mirror_next;
			if (sel_next && !rw_next)
			begin
				last_addr_reg <= mirror_next;
				last_data_reg <= wdata_next;
			end
			if (rewrite_reg)
				wrote_reg <= 1'b0;
			else if (take)
				wrote_reg <= !rw_next;
			rewrite_reg <= wrote_reg && !sel_next; // [RQ13]
			rd_sr_reg   <= {rd_sr_reg[1:0], issue_rd};
			valid_reg   <= valid_next;
			if (valid_next)
				rdata_reg <= ram.ram_data;
		end
	end

	// plain registered controls may fan out to parallel rams [RQ18]
	assign ram.select_active_low     = !sel_reg; // [RQ17]
	assign ram.select_active_high    = bank_reg;
	assign ram.read_write            = rw_reg;
	assign ram.address_strobe_n      = ads_reg;
	assign ram.counter_advance_n     = adv_reg;
	assign ram.counter_clear_n       = clr_reg;
	// ram drivers off while the host drives data
	assign ram.output_enable_n       = wr_reg;
	assign ram.output_latency_select = pipe_reg; // [RQ19]
	assign ram.address               = addr_reg;
	assign ram.host_data             = wdata_reg;
	assign ram.host_data_oe_n        = !wr_reg;
	assign rdata_o                   = rdata_reg;
	assign rdata_valid_o             = valid_reg;
endmodule
`default_nettype wire

// ==== verification/srpc_port_properties.sv ====
// concurrent checks on one port of the dual-port ram
`timescale 1ns/10ps
`default_nettype none
module srpc_port_properties
	import srpc_pkg::*;
(
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              resetn_i,
	// port controls
	input  wire logic              select_active_low,
	input  wire logic              select_active_high,
	input  wire logic              read_write,
	input  wire logic              address_strobe_n,
	input  wire logic              counter_advance_n,
	input  wire logic              counter_clear_n,
	input  wire logic              output_enable_n,
	input  wire logic              output_latency_select,
	input  wire logic [ADDR_W-1:0] address,
	// data lines
	input  wire logic [DATA_W-1:0] host_data,
	input  wire logic              host_data_oe_n,
	input  wire logic [DATA_W-1:0] ram_data,
	input  wire logic              ram_data_oe_n
);
	wire logic sel;
	wire logic rd_sel;
	wire logic hold_pins;
	assign sel = !select_active_low && select_active_high;
	assign rd_sel = sel && read_write;
	assign hold_pins = address_strobe_n && counter_advance_n && counter_clear_n;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	sequence s_flow_read;
		rd_sel && !output_latency_select;
	endsequence
	sequence s_pipe_read;
		rd_sel && output_latency_select;
	endsequence
	sequence s_load_write;
		sel && !read_write && !address_strobe_n && counter_clear_n
			&& !output_latency_select;
	endsequence
	sequence s_same_read;
		s_flow_read ##0 (!address_strobe_n && counter_clear_n
			&& address == $past(address));
	endsequence

	a_flow_drive_on: assert property (s_flow_read |=> output_enable_n || !ram_data_oe_n)
		else $error("flow read not driven next cycle");
	a_flow_drive_off: assert property (!output_latency_select && !rd_sel |=> ram_data_oe_n)
		else $error("driver on after idle or write cycle");
	a_pipe_wake: assert property (output_latency_select && !sel ##1 output_latency_select |=> ram_data_oe_n)
		else $error("pipelined driver on without two selected cycles");
	a_pipe_latency: assert property (s_pipe_read ##1 s_pipe_read ##1 output_latency_select |=> output_enable_n || !ram_data_oe_n)
		else $error("pipelined read not driven");
	a_oe_gates: assert property (output_enable_n |-> ram_data_oe_n)
		else $error("driver on while output enable off");
	a_no_contention: assert property (!host_data_oe_n |-> ram_data_oe_n)
		else $error("both ends drive data");
	a_host_write_rw: assert property (!host_data_oe_n |-> !read_write)
		else $error("host drives data in read cycle");
	a_hold_stable: assert property (s_flow_read ##1 (s_flow_read ##0 hold_pins) |=> $stable(ram_data))
		else $error("held address changed read data");
	a_write_read: assert property (s_load_write ##1 s_same_read |=> ram_data == $past(host_data, 2))
		else $error("read after write gave wrong data");
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// testbench: two hosts drive both ports of the dual-port ram
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
	mismatches++; $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module tb;
	import srpc_pkg::*;
	logic              clock;
	logic              resetn;
	logic              cmd_valid [2];
	srpc_op_t          cmd_op [2];
	logic [ADDR_W-1:0] cmd_addr [2];
	logic [DATA_W-1:0] cmd_wdata [2];
	logic              pipelined [2];
	logic              bank_enable [2];
	logic              cmd_ready [2];
	logic [DATA_W-1:0] rdata [2];
	logic              rdata_valid [2];
	logic [ADDR_W-1:0] cnt [2];
	logic [DATA_W-1:0] mem [int];
	logic [DATA_W-1:0] eq [2][$];
	int                tq [2][$];
	int                cyc = 0;
	int                mismatches = 0;
	int                checks_done = 0;
	logic [31:0]       seed = 32'hD58C;

	srpc_port_if port [2] ();
	srpc_ram srpc_ram_i (.clock_i(clock), .resetn_i(resetn),
		.port_a(port[0]), .port_b(port[1]));
	for (genvar g = 0; g < 2; g++)
	begin : gen_host
		srpc_host srpc_host_i (.clock_i(clock), .resetn_i(resetn),
			.ram(port[g]), .cmd_valid_i(cmd_valid[g]), .cmd_op_i(cmd_op[g]),
			.cmd_addr_i(cmd_addr[g]), .cmd_wdata_i(cmd_wdata[g]),
			.pipelined_i(pipelined[g]), .bank_enable_i(bank_enable[g]),
			.cmd_ready_o(cmd_ready[g]), .rdata_o(rdata[g]),
			.rdata_valid_o(rdata_valid[g]));
	end
	srpc_port_properties srpc_port_properties_i (
		.clock_i(clock), .resetn_i(resetn),
		.select_active_low(port[0].select_active_low),
		.select_active_high(port[0].select_active_high),
		.read_write(port[0].read_write),
		.address_strobe_n(port[0].address_strobe_n),
		.counter_advance_n(port[0].counter_advance_n),
		.counter_clear_n(port[0].counter_clear_n),
		.output_enable_n(port[0].output_enable_n),
		.output_latency_select(port[0].output_latency_select),
		.address(port[0].address), .host_data(port[0].host_data),
		.host_data_oe_n(port[0].host_data_oe_n),
		.ram_data(port[0].ram_data), .ram_data_oe_n(port[0].ram_data_oe_n));

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) cyc <= cyc + 1;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// counter and array model, applied at the falling edge before the host takes a command
	function automatic void take(input int p);
		case (cmd_op[p])
			OP_READ, OP_WRITE: cnt[p] = cmd_addr[p];
			OP_NEXT_READ, OP_NEXT_WRITE: cnt[p] = cnt[p] + 1'b1;
			OP_CLEAR_READ: cnt[p] = COUNT_RST;
			default: ;
		endcase
		if (!bank_enable[p])
			return;
		if (cmd_op[p] == OP_WRITE || cmd_op[p] == OP_NEXT_WRITE)
			mem[cnt[p]] = cmd_wdata[p];
		else
		begin
			eq[p].push_back(mem[cnt[p]]);
			tq[p].push_back(cyc + 1 + (pipelined[p] ? PIPE_LAT + 1 : FT_LAT + 1));
		end
	endfunction

	always @(negedge clock)
	begin
		logic [DATA_W-1:0] ex;
		int et;
		for (int p = 0; p < 2; p++)
		begin
			if (resetn && cmd_valid[p] && cmd_ready[p] === 1'b1)
				take(p);
			if (rdata_valid[p] === 1'b1 && eq[p].size() == 0)
				`CHK("unexpected valid", 1'b0, 1'b1)
			else if (rdata_valid[p] === 1'b1)
			begin
				ex = eq[p].pop_front();
				et = tq[p].pop_front();
				`CHK("rdata", ex, rdata[p])
				`CHK("latency", et, cyc)
			end
		end
	end

	// holds the command until the host takes it or 50 falling edges pass; valid stays up
	task automatic drive(input int p, input srpc_op_t op,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		cmd_valid[p] <= 1'b1;
		cmd_op[p] <= op;
		cmd_addr[p] <= a;
		cmd_wdata[p] <= d;
		do @(negedge clock); while (cmd_ready[p] !== 1'b1 && ++n < 50);
		`CHK("cmd ready", 1'b1, cmd_ready[p])
		@(posedge clock);
	endtask

	task automatic rnd_run(input int p, input int count);
		logic [31:0] r;
		srpc_op_t op;
		for (int i = 0; i < count; i++)
		begin
			r = rnd();
			op = srpc_op_t'(r[10:8] % 6);
			if (p == 1 && op == OP_CLEAR_READ)
				op = OP_HOLD_READ;
			if (r[3:0] == 4'h0)
			begin
				cmd_valid[p] <= 1'b0;
				repeat (r[5:4] + 1) @(posedge clock);
			end
			else
				drive(p, op, {p == 1, 8'h00, r[23:16]}, r[31:24]);
		end
		cmd_valid[p] <= 1'b0;
	endtask

	task automatic fill(input int p);
		drive(p, OP_WRITE, {p == 1, 16'h0000}, rnd());
		for (int i = 1; i < 320; i++)
			drive(p, OP_NEXT_WRITE, 17'h00000, rnd());
		cmd_valid[p] <= 1'b0;
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	srpc_op_t burst [10] = '{OP_WRITE, OP_READ, OP_NEXT_READ, OP_NEXT_READ,
		OP_HOLD_READ, OP_HOLD_READ, OP_CLEAR_READ, OP_NEXT_WRITE,
		OP_CLEAR_READ, OP_NEXT_READ};

	initial
	begin
		for (int p = 0; p < 2; p++)
		begin
			cmd_valid[p] = 1'b0;
			cmd_op[p] = OP_READ;
			cmd_addr[p] = '0;
			cmd_wdata[p] = '0;
			pipelined[p] = 1'b0;
			bank_enable[p] = 1'b1;
			cnt[p] = COUNT_RST;
		end
		resetn = 1'b0;
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		fork
			fill(0);
			fill(1);
		join
		// cross-port reads one edge after the other side writes
		drive(0, OP_WRITE, 17'h00005, 8'h5A);
		cmd_valid[0] <= 1'b0;
		drive(1, OP_READ, 17'h00005, 8'h00);
		drive(1, OP_WRITE, 17'h00006, 8'hA5);
		cmd_valid[1] <= 1'b0;
		drive(0, OP_READ, 17'h00006, 8'h00);
		drive(0, OP_READ, 17'h00005, 8'h00);
		// load, advance, stall, clear with access
		for (int i = 0; i < 10; i++)
			drive(0, burst[i], 17'h00007, 8'hC3);
		cmd_valid[0] <= 1'b0;
		// deselected bank neither writes nor answers
		bank_enable[1] <= 1'b0;
		drive(1, OP_WRITE, 17'h10003, 8'hEE);
		drive(1, OP_READ, 17'h10003, 8'h00);
		bank_enable[1] <= 1'b1;
		drive(1, OP_READ, 17'h10003, 8'h00);
		cmd_valid[1] <= 1'b0;
		for (int m = 0; m < 2; m++)
		begin
			repeat (4) @(posedge clock);
			pipelined[0] <= m == 1;
			pipelined[1] <= m == 1;
			repeat (4) @(posedge clock);
			fork
				rnd_run(0, 150);
				rnd_run(1, 150);
			join
		end
		repeat (8) @(posedge clock);
		`CHK("pending a", 0, eq[0].size())
		`CHK("pending b", 0, eq[1].size())
		give_verdict();
	end

	initial
	begin
		repeat (20000) @(posedge clock);
		mismatches++;
		give_verdict();
	end
endmodule
`default_nettype wire
